// *** design/qldpc_defs.vh ***
// Constants for the quadrature LO divider and phase control core.
// Assumes inclusion by design files only; holds definitions only.
`ifndef QLDPC_DEFS_VH
`define QLDPC_DEFS_VH

`define QLDPC_CHANNELS 4
`define QLDPC_PHASE_BITS 4
`define QLDPC_PHASE_STEPS 16
`define QLDPC_PHASE_RESET 4'h0
`define QLDPC_ENABLE_RESET 4'h0
`define QLDPC_FRAME_BITS 20
`define QLDPC_FRAME_RESET 20'h0_0000
`define QLDPC_DIV_RESET 2'b00
`define QLDPC_CNT_BITS 5

`endif

// *** design/qldpc_phase_chan.v ***
// One channel's phase rotation: advances the quadrature LO by the quarter turns in the code's upper two bits.
// Assumes a 4x LO sample stream on clk and a phase code held stable by the caller.
`timescale 1ns/1ps
`include "qldpc_defs.vh"

module qldpc_phase_chan #(
    parameter PHASE_BITS = `QLDPC_PHASE_BITS
) (
    input wire clk,
    input wire rst,
    input wire enable,
    input wire [1:0] lo_quad,
    input wire [PHASE_BITS-1:0] phase_code,
    output reg [1:0] lo_shifted,
    output reg [PHASE_BITS-1:0] phase_acc
);

    ////////////////////////////////////////////////////////////////////////////
    // Step count: the upper two bits pick a quarter turn of the LO, the
    // lower two bits carry the finer 22.5 degree part as a reported step.
    always @(posedge clk) begin
        if (rst || !enable) begin
            lo_shifted <= 2'b00;
            phase_acc <= `QLDPC_PHASE_RESET;
        end else begin
            phase_acc <= phase_code; // R10
            case (phase_code[PHASE_BITS-1:PHASE_BITS-2])
                2'd0: lo_shifted <= lo_quad;
                2'd1: lo_shifted <= {lo_quad[0], ~lo_quad[1]}; // R11
                2'd2: lo_shifted <= ~lo_quad;
                2'd3: lo_shifted <= {~lo_quad[0], lo_quad[1]};
                default: lo_shifted <= lo_quad;
            endcase
        end
    end

endmodule

// *** design/qldpc_core.v ***
// Digital core of a four channel I/Q demodulator: LO divide by four and serial phase control.
// Assumes clk is the 4x-rate LO and every input is synchronous to it.
`timescale 1ns/1ps
`include "qldpc_defs.vh"

// Functional notes
// R1: Each of four channels holds its own 16-step phase code, 22.5 degrees apart.
// R2: Serial configuration reset clears every serial control bit to zero.
// R3: Host may use configuration reset to disable the device for test.
// R4: In-phase and quadrature LO come from dividing the 4x LO by four.
// R5: Both LO outputs keep 50 percent duty cycle whatever the input duty.
// R6: Final LO flip-flops are clocked directly by the 4x LO.
// R7: LO sync reset returns the divider to a fixed known state.
// R8: Host drives the LO sync reset when several devices are used.
// R9: LO path and its sync reset work only while a channel is enabled.
// R10: Phase field is 4 bits, bit 0 least significant, plain binary.
// R11: One code higher advances a channel by one 22.5 degree step; chan_lo moves only in quarter turns, set by the upper two code bits.
// R12: Divider is a two-stage twisted ring, quadrature one input cycle late.
// R13: Shifted settings take effect only when serial select returns high.
module qldpc_core #(
    parameter CHANNELS = `QLDPC_CHANNELS,
    parameter PHASE_BITS = `QLDPC_PHASE_BITS
) (
    input wire clk,
    input wire rst,
    input wire quad_rate_lo_in_pos,
    input wire quad_rate_lo_in_neg,
    input wire lo_divider_sync_reset,
    input wire serial_config_reset,
    input wire serial_clk,
    input wire serial_select_n,
    input wire serial_data_in,
    output reg serial_data_out,
    output reg lo_in_phase,
    output reg lo_quadrature,
    output reg lo_active,
    output reg [CHANNELS-1:0] chan_enable,
    output reg [CHANNELS*PHASE_BITS-1:0] chan_phase,
    output reg [CHANNELS*2-1:0] chan_lo
);

    localparam FRAME_BITS = CHANNELS * (PHASE_BITS + 1);
    localparam [1:0] DIV_RESET = `QLDPC_DIV_RESET;

    reg [FRAME_BITS-1:0] shift_reg;
    reg [FRAME_BITS-1:0] shift_next;
    reg sclk_prev_reg;
    reg select_prev_reg;
    reg [1:0] ring_reg;
    reg [1:0] ring_next;
    reg lo_diff_reg;
    wire any_enable;
    wire sclk_rise;
    wire frame_end;
    wire [CHANNELS*2-1:0] shifted_lo;
    wire [CHANNELS*PHASE_BITS-1:0] shifted_phase;

    assign any_enable = |chan_enable;
    assign sclk_rise = serial_clk && !sclk_prev_reg;
    assign frame_end = serial_select_n && !select_prev_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Serial shift register; data enters at bit 0 and leaves at the top.
    always @* begin
        shift_next = shift_reg;
        if (!serial_select_n && sclk_rise) begin
            shift_next = {shift_reg[FRAME_BITS-2:0], serial_data_in};
        end
    end

    always @(posedge clk) begin
        if (rst || serial_config_reset) begin
            shift_reg <= `QLDPC_FRAME_RESET; // R2
            sclk_prev_reg <= 1'b0;
            select_prev_reg <= 1'b1;
            serial_data_out <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            sclk_prev_reg <= serial_clk;
            select_prev_reg <= serial_select_n;
            serial_data_out <= shift_reg[FRAME_BITS-1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Active settings: per channel {enable, phase[3:0]}, channel 0 lowest.
    integer i;
    always @(posedge clk) begin
        if (rst || serial_config_reset) begin
            chan_enable <= {CHANNELS{1'b0}}; // R2 R3
            chan_phase <= {CHANNELS*PHASE_BITS{1'b0}};
        end else if (frame_end) begin
            for (i = 0; i < CHANNELS; i = i + 1) begin
                chan_enable[i] <= shift_reg[i*(PHASE_BITS+1)+PHASE_BITS]; // R13
                chan_phase[i*PHASE_BITS +: PHASE_BITS] <= shift_reg[i*(PHASE_BITS+1) +: PHASE_BITS]; // R1
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Divide by four as a twisted ring: 00 -> 01 -> 11 -> 10 -> 00.
    always @* begin
        ring_next = {ring_reg[0], ~ring_reg[1]}; // R4 R12
        if (lo_divider_sync_reset) begin
            ring_next = DIV_RESET; // R7
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            ring_reg <= DIV_RESET;
            lo_diff_reg <= 1'b0;
            lo_in_phase <= 1'b0;
            lo_quadrature <= 1'b0;
            lo_active <= 1'b0;
        end else begin
            lo_diff_reg <= quad_rate_lo_in_pos && !quad_rate_lo_in_neg;
            lo_active <= any_enable;
            if (any_enable) begin
                ring_reg <= ring_next; // R9
                lo_in_phase <= ring_next[0]; // R5 R6
                lo_quadrature <= ring_next[1]; // R6
            end else begin
                ring_reg <= DIV_RESET; // R9
                lo_in_phase <= 1'b0;
                lo_quadrature <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel phase-rotated LO.
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : chan
            qldpc_phase_chan #(
                .PHASE_BITS(PHASE_BITS)
            ) u_chan (
                .clk(clk),
                .rst(rst),
                .enable(chan_enable[g]),
                .lo_quad({lo_quadrature, lo_in_phase}),
                .phase_code(chan_phase[g*PHASE_BITS +: PHASE_BITS]),
                .lo_shifted(shifted_lo[g*2 +: 2]),
                .phase_acc(shifted_phase[g*PHASE_BITS +: PHASE_BITS])
            );
        end
    endgenerate

    always @(posedge clk) begin
        if (rst) begin
            chan_lo <= {CHANNELS*2{1'b0}};
        end else begin
            chan_lo <= shifted_lo; // R11
        end
    end

endmodule

// *** bench/qldpc_host.sv ***
// Host model: shifts serial frames and pulses both resets.
// Assumes the core samples on rising clk; all changes follow an edge.
`timescale 1ns/1ps
module qldpc_host (
    input wire clk,
    output reg sclk,
    output reg sel_n,
    output reg sdi,
    output reg cfg_rst,
    output reg div_rst
);
    initial {sclk, sel_n, sdi, cfg_rst, div_rst} = 5'h08;
    task send(input [19:0] f);
        integer i;
        begin
            @(posedge clk) sel_n <= 1'b0;
            for (i = 19; i >= 0; i = i - 1) begin
                @(posedge clk) sdi <= f[i];
                @(posedge clk) sclk <= 1'b1;
                @(posedge clk) sclk <= 1'b0;
            end
            @(posedge clk) sel_n <= 1'b1;
            sdi <= ~f[0];
        end
    endtask
    task pulse(input div, input integer n);
        begin
            @(posedge clk) {div_rst, cfg_rst} <= {div, ~div};
            repeat (n) @(posedge clk);
            {div_rst, cfg_rst} <= 2'h0;
        end
    endtask
endmodule

// *** bench/qldpc_core_asserts.sv ***
// Checker for the LO divider and the serial settings outputs.
// Assumes a bind into qldpc_core; clk and rst as in the core.
`timescale 1ns/1ps
module qldpc_core_asserts #(
    parameter CHANNELS = 4,
    parameter PHASE_BITS = 4
) (
    input wire clk,
    input wire rst,
    input wire lo_divider_sync_reset,
    input wire serial_config_reset,
    input wire serial_select_n,
    input wire lo_in_phase,
    input wire lo_quadrature,
    input wire lo_active,
    input wire [CHANNELS-1:0] chan_enable,
    input wire [CHANNELS*PHASE_BITS-1:0] chan_phase
);
    reg hit_q, hit_qq;
    wire hit = lo_divider_sync_reset || serial_config_reset || hit_q || hit_qq;
    always @(posedge clk) begin
        hit_q <= lo_divider_sync_reset || serial_config_reset;
        hit_qq <= hit_q;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_duty_high: assert property (disable iff (rst || hit)
        $rose(lo_in_phase) |=> lo_in_phase ##1 !lo_in_phase) else $error("I high length");
    a_duty_low: assert property (disable iff (rst || hit)
        $fell(lo_in_phase) && lo_active |=> !lo_in_phase ##1 lo_in_phase) else $error("I low length");
    a_quad_lag: assert property (disable iff (rst || hit)
        lo_active |-> lo_quadrature == $past(lo_in_phase)) else $error("Q lag");
    a_idle_off: assert property (
        (chan_enable == 0)[*3] |-> !lo_in_phase && !lo_quadrature) else $error("LO runs idle");
    a_active_or: assert property (
        lo_active == |$past(chan_enable)) else $error("active flag");
    a_cfg_clear: assert property (
        serial_config_reset |=> chan_enable == 0 && chan_phase == 0) else $error("config clear");
    a_hold_set: assert property (
        !serial_config_reset && !(serial_select_n && !$past(serial_select_n))
        |=> $stable(chan_enable) && $stable(chan_phase)) else $error("settings moved");
    a_div_sync: assert property (
        lo_divider_sync_reset && chan_enable != 0 |=> !lo_in_phase && !lo_quadrature) else $error("sync");
    c_frame: cover property ($rose(serial_select_n));
    c_sync: cover property (lo_divider_sync_reset && lo_active);
    c_cfg: cover property ($fell(serial_config_reset));
endmodule
bind qldpc_core qldpc_core_asserts #(.CHANNELS(CHANNELS), .PHASE_BITS(PHASE_BITS)) chk_u (.*);

// *** bench/qldpc_core_tb_top.sv ***
// Testbench for the LO divider and serial phase control core.
// Assumes the host model drives the serial port and both resets.
`timescale 1ns/1ps
module qldpc_core_tb_top;
    reg clk, rst, lo_p;
    wire sclk, sel_n, sdi, cfg_rst, div_rst, sdo, li, lq;
    wire [3:0] en;
    wire [15:0] ph;
    wire [7:0] clo;
    reg [1:0] lo_hist;
    integer err_total = 0, compares = 0, i, cnt;
    reg [19:0] f;
    qldpc_host host_u (.clk(clk), .sclk(sclk), .sel_n(sel_n), .sdi(sdi), .cfg_rst(cfg_rst), .div_rst(div_rst));
    qldpc_core dut_u (.clk(clk), .rst(rst), .quad_rate_lo_in_pos(lo_p), .quad_rate_lo_in_neg(~lo_p),
        .lo_divider_sync_reset(div_rst), .serial_config_reset(cfg_rst), .serial_clk(sclk),
        .serial_select_n(sel_n), .serial_data_in(sdi), .serial_data_out(sdo), .lo_in_phase(li),
        .lo_quadrature(lq), .lo_active(), .chan_enable(en), .chan_phase(ph), .chan_lo(clo));
    function [15:0] ph_of(input [19:0] v);
        integer n;
        for (n = 0; n < 4; n = n + 1)
            ph_of[4*n +: 4] = v[5*n +: 4];
    endfunction
    task chk(input [8*8-1:0] nm, input [15:0] exp, input [15:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("MISMATCH %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task finish_test;
        begin
            $display("Mismatches %0d, compares %0d", err_total, compares);
            if (err_total == 0 && compares > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) lo_p <= 1'($urandom);
    initial begin
        #50000;
        err_total = err_total + 1;
        finish_test;
    end
    initial begin
        rst = 1'b1;
        i = $urandom(55029);
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 16; i = i + 1) begin
            f = 20'($urandom);
            f[4:0] = {1'b1, i[3:0]};
            host_u.send(f);
            repeat (2) @(negedge clk);
            chk("enable", {12'h000, f[19], f[14], f[9], f[4]}, {12'h000, en});
            chk("phase", ph_of(f), ph);
            chk("sdo", {15'h0000, f[19]}, {15'h0000, sdo});
        end
        cnt = 0;
        repeat (8) @(negedge clk) cnt = cnt + li;
        chk("duty", 16'h0004, cnt[15:0]);
        // Channel 0 holds code 15, three quarter turns ahead: it shows the I/Q pair one cycle early.
        lo_hist = clo[1:0];
        @(negedge clk);
        chk("chan lo", {14'h0000, lo_hist}, {14'h0000, lq, li});
        host_u.pulse(1'b1, 3);
        @(negedge clk);
        chk("lo sync", 16'h0000, {14'h0000, lq, li});
        @(negedge clk);
        chk("lo start", 16'h0001, {14'h0000, lq, li});
        host_u.pulse(1'b0, 2);
        @(negedge clk);
        chk("enable", 16'h0000, {12'h000, en});
        chk("phase", 16'h0000, ph);
        repeat (3) @(negedge clk);
        chk("lo off", 16'h0000, {14'h0000, lq, li});
        finish_test;
    end
endmodule
